// ===== logic/spm_ctrl.sv
// Purpose: Self-program sequencer with fuse and lock readback
// Assumes: Core writes control, then issues load/store strobes on clk_sys_i
// Notes:   Flash array and fuse storage live outside; this block times and steers
//
// Contract
// - Pointer 0001 armed load returns lock byte
// - Arming bits auto-clear on completion or expiry; a long operation ending while clk_en_i is low leaves them set
// - Unarmed load is an ordinary flash fetch
// - Pointer 0000 armed load returns fuse low
// - Pointer 0003 armed load returns fuse high
// - Programmed bits read zero, unprogrammed read one
// - Reset does not abort a running write
// - Erase and write last 3.7 to 4.5 ms
// - Block read section fetches during erase/write
// - Busy flag readable while read section blocked
// - Interrupt held while enable bit clear
// - EEPROM write blocks programming and readback
`timescale 1ns/10ps
module spm_ctrl
  import spm_ctrl_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_MIN_CYC + (PROG_MAX_CYC - PROG_MIN_CYC) / 2
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        clk_en_i,
  // Control byte write from core
  input  wire logic        ctrl_wr_i,
  input  wire logic [7:0]  ctrl_wdata_i,
  output logic      [7:0]  ctrl_rdata_o,
  // Instruction strobes
  input  wire logic        load_instr_i,
  input  wire logic        store_instr_i,
  input  wire logic [15:0] pointer_i,
  output logic      [7:0]  load_data_o,
  // Flash array side
  input  wire logic [7:0]  flash_byte_i,
  input  wire logic        fetch_rww_i,
  output logic             fetch_block_o,
  output logic             flash_erase_o,
  output logic             flash_write_o,
  output logic             lock_write_o,
  output logic             buffer_fill_o,
  output logic             flash_busy_o,
  // Fuse and lock storage, 0 = programmed
  input  wire logic [7:0]  fuse_low_byte_i,
  input  wire logic [7:0]  fuse_high_byte_i,
  input  wire logic [7:0]  lock_byte_i,
  // EEPROM status and interrupt
  input  wire logic        eeprom_write_flag_i,
  output logic             spm_irq_o
);

  initial begin
    if (PROG_CYCLES < PROG_MIN_CYC || PROG_CYCLES > PROG_MAX_CYC) begin
      $error("PROG_CYCLES outside programming time");
    end
    if (LOAD_WINDOW == 3'h0 || LOAD_WINDOW >= STORE_WINDOW) begin
      $error("Load window must be shorter than store window");
    end
  end

  localparam int CW = $clog2(PROG_MAX_CYC + 1);

  spm_cmd_t        cmd;
  logic [2:0]      win_cnt;
  logic            rww_busy_flag;
  op_state_t       op_state;
  logic [CW-1:0]   op_cnt;

  function automatic logic is_readback(input spm_cmd_t c);
    return c.prog_enable && c.lock_set;
  endfunction

  wire logic armed_read    = is_readback(cmd) && !eeprom_write_flag_i;
  wire logic sel_fuse_low  = pointer_i == PTR_FUSE_LOW;
  wire logic sel_lock      = pointer_i == PTR_LOCK;
  wire logic sel_fuse_high = pointer_i == PTR_FUSE_HIGH;
  // Counter runs 4,3,2 during the three load cycles after the write
  wire logic read_hit      = load_instr_i && armed_read
                             && win_cnt > (STORE_WINDOW - LOAD_WINDOW);
  wire logic store_go      = store_instr_i && cmd.prog_enable && win_cnt != 3'h0
                             && !eeprom_write_flag_i && op_state == OP_IDLE;
  wire logic go_erase      = store_go && cmd.page_erase;
  wire logic go_write      = store_go && cmd.page_write;
  wire logic go_lock       = store_go && cmd.lock_set;
  wire logic go_reen       = store_go && cmd.reenable;
  wire logic go_fill       = store_go && !cmd.page_erase && !cmd.page_write
                             && !cmd.lock_set && !cmd.reenable;
  wire logic expire        = cmd.prog_enable && win_cnt == 3'h1 && !store_go;
  wire logic read_expire   = armed_read && win_cnt == (STORE_WINDOW - LOAD_WINDOW)
                             && !read_hit;
  wire logic op_end        = op_state == OP_BUSY && op_cnt == CW'(PROG_CYCLES - 1);
  wire logic ctrl_take     = ctrl_wr_i && !eeprom_write_flag_i && op_state == OP_IDLE;

  // Readback byte, fuse storage already carries programmed-as-zero polarity
  wire logic [7:0] readback =
    sel_lock      ? lock_byte_i      :
    sel_fuse_high ? fuse_high_byte_i :
    sel_fuse_low  ? fuse_low_byte_i  : 8'hFF;

  // Arming window counter, loaded by each control write taken while idle with no EEPROM write pending
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      win_cnt <= 3'h0;
    end else if (clk_en_i) begin
      if (ctrl_take) begin
        win_cnt <= STORE_WINDOW;
      end else if (read_hit || store_go || expire) begin
        win_cnt <= 3'h0;
      end else if (win_cnt != 3'h0) begin
        win_cnt <= win_cnt - 3'h1;
      end
    end
  end

  // Command bits; prog_enable stays up until a long operation ends
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cmd <= '0;
    end else if (clk_en_i) begin
      if (ctrl_take) begin
        cmd.irq_enable  <= ctrl_wdata_i[IE_BIT];
        cmd.reenable    <= ctrl_wdata_i[REEN_BIT];
        cmd.lock_set    <= ctrl_wdata_i[LBS_BIT];
        cmd.page_write  <= ctrl_wdata_i[WRT_BIT];
        cmd.page_erase  <= ctrl_wdata_i[ERS_BIT];
        cmd.prog_enable <= ctrl_wdata_i[SPE_BIT];
      end else if (read_hit || read_expire || expire ||
                   (store_go && !(go_erase || go_write || go_lock)) || op_end) begin
        cmd.reenable    <= 1'b0;
        cmd.lock_set    <= 1'b0;
        cmd.page_write  <= 1'b0;
        cmd.page_erase  <= 1'b0;
        cmd.prog_enable <= 1'b0;
      end
    end
  end

  // Long operation timer; keeps it out of the synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i && op_state != OP_BUSY) begin
      op_state <= OP_IDLE;
      op_cnt   <= '0;
    end else if (clk_en_i || op_state == OP_BUSY) begin
      case (op_state)
        OP_IDLE: begin
          op_cnt <= '0;
          if (go_erase || go_write || go_lock) begin
            op_state <= OP_BUSY;
          end
        end
        OP_BUSY: begin
          op_cnt <= op_cnt + CW'(1);
          if (op_end) begin
            op_state <= OP_DONE;
          end
        end
        OP_DONE: op_state <= OP_IDLE;
        default: op_state <= OP_IDLE;
      endcase
    end
  end

  // Read section busy until software re-enables it
  always_ff @(posedge clk_sys_i) begin
    if (srst_i && op_state == OP_IDLE) begin
      rww_busy_flag <= 1'b0;
    end else if (clk_en_i || op_state == OP_BUSY) begin
      if (go_erase || go_write) begin
        rww_busy_flag <= 1'b1;
      end else if (go_reen && op_state == OP_IDLE) begin
        rww_busy_flag <= 1'b0;
      end
    end
  end

  // Load data: substitution only while armed, else plain fetch
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      load_data_o <= 8'hFF;
    end else if (clk_en_i && load_instr_i) begin
      load_data_o <= read_hit ? readback : flash_byte_i;
    end
  end

  // Single-cycle command strobes to the array
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      lock_write_o  <= 1'b0;
      buffer_fill_o <= 1'b0;
    end else begin
      flash_erase_o <= clk_en_i && go_erase;
      flash_write_o <= clk_en_i && go_write;
      lock_write_o  <= clk_en_i && go_lock;
      buffer_fill_o <= clk_en_i && go_fill;
    end
  end

  assign fetch_block_o = rww_busy_flag && fetch_rww_i;
  assign flash_busy_o  = op_state == OP_BUSY;
  assign spm_irq_o     = cmd.irq_enable && !cmd.prog_enable;
  assign ctrl_rdata_o  = {cmd.irq_enable, rww_busy_flag, 1'b0, cmd.reenable,
                          cmd.lock_set, cmd.page_write, cmd.page_erase,
                          cmd.prog_enable};

  // Checks
  sequence armed_s;
    ctrl_take && ctrl_wdata_i[SPE_BIT] && ctrl_wdata_i[LBS_BIT];
  endsequence

  sequence store_armed_s;
    ctrl_take && ctrl_wdata_i[SPE_BIT] && !ctrl_wdata_i[LBS_BIT];
  endsequence

  sequence quiet_s;
    clk_en_i && !load_instr_i && !store_instr_i && !ctrl_wr_i;
  endsequence

  // Command strobes toward the array, and re-enable clearing the busy flag
  fill_pulse_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && go_fill |=> buffer_fill_o ##1 !buffer_fill_o)
    else $error("fill strobe wrong");
  erase_pulse_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && go_erase |=> flash_erase_o && flash_busy_o)
    else $error("erase strobe wrong");
  write_pulse_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && go_write |=> flash_write_o && flash_busy_o)
    else $error("write strobe wrong");
  lock_pulse_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && go_lock |=> lock_write_o && flash_busy_o)
    else $error("lock write strobe wrong");
  reen_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && go_reen && !cmd.page_erase && !cmd.page_write |=> !rww_busy_flag)
    else $error("busy flag not cleared");

  // Arming window behaviour
  read_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && read_hit && !ctrl_take |=> !cmd.prog_enable && !cmd.lock_set)
    else $error("arming bits kept after readback");
  store_expire_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    store_armed_s ##1 quiet_s[*4] |=> !cmd.prog_enable)
    else $error("store window not expired");
  late_load_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && load_instr_i && win_cnt == 3'h1 |=> load_data_o == $past(flash_byte_i))
    else $error("late load substituted");
  store_take_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && store_go && !ctrl_take |=> win_cnt == 3'h0)
    else $error("window kept after store");
  win_bound_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    win_cnt <= STORE_WINDOW)
    else $error("window counter out of range");
  unknown_ptr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && read_hit && !sel_lock && !sel_fuse_low && !sel_fuse_high
    |=> load_data_o == 8'hFF)
    else $error("unknown pointer readback wrong");

  // Status, interrupt and reset survival
  irq_off_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !cmd.irq_enable |-> !spm_irq_o)
    else $error("interrupt without enable");
  flag_view_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ctrl_rdata_o[BUSY_BIT] == rww_busy_flag)
    else $error("busy flag not visible");
  busy_timer_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    flash_busy_o |-> op_cnt < CW'(PROG_CYCLES))
    else $error("operation timer overran");
  reset_keeps_a: assert property (@(posedge clk_sys_i)
    srst_i && flash_busy_o && !op_end |=> flash_busy_o)
    else $error("reset aborted operation");

  lock_readback_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && read_hit && sel_lock |=> load_data_o == $past(lock_byte_i))
    else $error("lock byte not returned");
  fuse_low_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && read_hit && sel_fuse_low |=> load_data_o == $past(fuse_low_byte_i))
    else $error("fuse low byte not returned");
  fuse_high_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && read_hit && sel_fuse_high |=> load_data_o == $past(fuse_high_byte_i))
    else $error("fuse high byte not returned");
  plain_fetch_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && load_instr_i && !is_readback(cmd) |=> load_data_o == $past(flash_byte_i))
    else $error("unarmed load substituted");
  arm_expire_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    armed_s ##1 (clk_en_i && !load_instr_i && !store_instr_i && !ctrl_wr_i)[*4]
    |=> !cmd.prog_enable)
    else $error("arming bits not cleared");
  irq_level_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    cmd.irq_enable && !cmd.prog_enable |-> spm_irq_o)
    else $error("interrupt not held");
  ee_block_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    eeprom_write_flag_i |-> !store_go && !read_hit)
    else $error("eeprom write did not block");
  rww_block_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    flash_busy_o && fetch_rww_i && rww_busy_flag |-> fetch_block_o)
    else $error("read section not blocked");
  busy_flag_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    clk_en_i && (go_erase || go_write) |=> ctrl_rdata_o[BUSY_BIT])
    else $error("busy flag not set");
  op_len_a: assert property (@(posedge clk_sys_i)
    op_end |-> op_cnt == CW'(PROG_CYCLES - 1) && flash_busy_o)
    else $error("operation length wrong");

endmodule // spm_ctrl

// ===== common/spm_ctrl_pkg.sv
// Purpose: Shared constants and carriers for the self-program controller
// Assumes: 50 MHz system clock
// Notes:   Control byte bit positions follow the store_program_control layout
package spm_ctrl_pkg;

  // Control byte bit positions
  localparam int SPE_BIT   = 0;
  localparam int ERS_BIT   = 1;
  localparam int WRT_BIT   = 2;
  localparam int LBS_BIT   = 3;
  localparam int REEN_BIT  = 4;
  localparam int BUSY_BIT  = 6;
  localparam int IE_BIT    = 7;

  // Pointer values that select fuse or lock readback
  localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] PTR_LOCK      = 16'h0001;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

  // Arming windows in CPU cycles
  localparam logic [2:0] LOAD_WINDOW  = 3'h3;
  localparam logic [2:0] STORE_WINDOW = 3'h4;

  // Flash operation time from the calibrated oscillator
  localparam int CLK_HZ        = 50_000_000;
  localparam int PROG_MIN_US   = 3700;
  localparam int PROG_MAX_US   = 4500;
  localparam int PROG_MIN_CYC  = (PROG_MIN_US * (CLK_HZ / 1_000_000));
  localparam int PROG_MAX_CYC  = (PROG_MAX_US * (CLK_HZ / 1_000_000));

  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'h0,
    OP_BUSY  = 2'h1,
    OP_DONE  = 2'h3
  } op_state_t;

  // Command fields written by the core
  typedef struct packed {
    logic irq_enable;
    logic reenable;
    logic lock_set;
    logic page_write;
    logic page_erase;
    logic prog_enable;
  } spm_cmd_t;

endpackage

// ===== testbench/spm_core_model.sv
// Purpose: Core model issuing control writes and load/store strobes
// Assumes: Called from the bench; drives on rising edges by non-blocking assignment
// Notes:   Released write data shows the inverse of the last byte
`timescale 1ns/10ps
module spm_core_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Core strobes
  output logic             ctrl_wr_o,
  output logic      [7:0]  ctrl_wdata_o,
  output logic             load_o,
  output logic             store_o,
  output logic      [15:0] pointer_o,
  output logic             load_seen_o
);
  initial begin
    ctrl_wr_o    = 1'b0;
    ctrl_wdata_o = 8'h00;
    load_o       = 1'b0;
    store_o      = 1'b0;
    pointer_o    = 16'hFFFF;
    load_seen_o  = 1'b0;
  end
  // Marks the cycle in which the load result has landed
  always @(posedge clk_sys_i) load_seen_o <= load_o;

  // Operation picked by the command bit combination
  task automatic write_ctrl(input logic [7:0] d);
    @(posedge clk_sys_i);
    ctrl_wr_o    <= 1'b1;
    ctrl_wdata_o <= d;
    @(posedge clk_sys_i);
    ctrl_wr_o    <= 1'b0;
    ctrl_wdata_o <= ~d;
  endtask

  task automatic load(input logic [15:0] p);
    @(posedge clk_sys_i);
    load_o    <= 1'b1;
    pointer_o <= p;
    @(posedge clk_sys_i);
    load_o    <= 1'b0;
  endtask

  task automatic store();
    @(posedge clk_sys_i);
    store_o <= 1'b1;
    @(posedge clk_sys_i);
    store_o <= 1'b0;
  endtask
endmodule // spm_core_model

// ===== testbench/spm_ctrl_tb_top.sv
// Purpose: Self-checking bench for the self-program controller
// Assumes: Timed operation too long to finish here, so only its start is seen
// Notes:   Load results are checked from a queue of expected bytes
`timescale 1ns/10ps
module spm_ctrl_tb_top;
  import spm_ctrl_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1, fetch_rww_i = 1'b0, eeprom_i = 1'b0, clk_en = 1'b1;
  logic [7:0]  flash_b = 8'h00, fuse_lo = 8'h00, fuse_hi = 8'h00, lock_b = 8'h00;
  wire logic   ctrl_wr, load, store, load_seen, fetch_block, erase, wr, lockw, fill, busy, irq;
  wire logic [7:0]  wdata, rdata, load_data;
  wire logic [15:0] ptr;
  int          bad_count = 0, samples_checked = 0, cycles = 0;
  logic [31:0] rng = 32'h1C38;
  logic [7:0]  exp_q[$];

  always #10 clk_sys_i = ~clk_sys_i;

  spm_core_model u_core (.clk_sys_i(clk_sys_i), .ctrl_wr_o(ctrl_wr), .ctrl_wdata_o(wdata),
    .load_o(load), .store_o(store), .pointer_o(ptr), .load_seen_o(load_seen));

  spm_ctrl dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .clk_en_i(clk_en), .ctrl_wr_i(ctrl_wr),
    .ctrl_wdata_i(wdata), .ctrl_rdata_o(rdata), .load_instr_i(load), .store_instr_i(store),
    .pointer_i(ptr), .load_data_o(load_data), .flash_byte_i(flash_b),
    .fetch_rww_i(fetch_rww_i), .fetch_block_o(fetch_block), .flash_erase_o(erase),
    .flash_write_o(wr), .lock_write_o(lockw), .buffer_fill_o(fill), .flash_busy_o(busy),
    .fuse_low_byte_i(fuse_lo), .fuse_high_byte_i(fuse_hi), .lock_byte_i(lock_b),
    .eeprom_write_flag_i(eeprom_i), .spm_irq_o(irq));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [15:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    u_core.load(p);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Result monitor: oldest expectation against the landed load byte
  always @(posedge clk_sys_i) begin
    if (load_seen === 1'b1) begin
      if (exp_q.size() == 0) bad_count++;
      else chk(load_data, exp_q.pop_front());
    end
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      @(posedge clk_sys_i);
      {flash_b, lock_b, fuse_hi, fuse_lo} <= rng;
      clk_en <= 1'b0;
      @(posedge clk_sys_i);
      clk_en <= 1'b1;
      u_core.write_ctrl(8'h09);
      rd(PTR_LOCK, lock_b);
      @(posedge clk_sys_i);
      #1 chk(rdata & 8'h09, 8'h00);
      u_core.write_ctrl(8'h09);
      rd(PTR_FUSE_LOW, fuse_lo);
      u_core.write_ctrl(8'h09);
      rd(PTR_FUSE_HIGH, fuse_hi);
      rd(PTR_LOCK, flash_b);
      u_core.write_ctrl(8'h09);
      repeat (4) @(posedge clk_sys_i);
      rd(PTR_FUSE_HIGH, flash_b);
      eeprom_i <= 1'b1;
      u_core.write_ctrl(8'h09);
      rd(PTR_FUSE_LOW, flash_b);
      eeprom_i <= 1'b0;
    end
    u_core.write_ctrl(8'h80);
    #1 chk(irq, 8'h01);
    u_core.write_ctrl(8'h81);
    #1 chk(irq, 8'h00);
    u_core.write_ctrl(8'h01);
    u_core.store();
    #1 chk({wr, lockw, fill, busy}, 8'h02);
    u_core.write_ctrl(8'h03);
    fetch_rww_i <= 1'b1;
    u_core.store();
    #1 chk({wr, lockw, erase, busy, rdata[BUSY_BIT]}, 8'h07);
    @(posedge clk_sys_i);
    #1 chk(fetch_block, 8'h01);
    srst_i <= 1'b1;
    @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 chk({busy, rdata[BUSY_BIT]}, 8'h03);
    repeat (500) @(posedge clk_sys_i);
    #1 chk({busy, fetch_block}, 8'h03);
    end_sim();
  end
endmodule // spm_ctrl_tb_top
